//--- rtl/rss_pkg.sv
package rss_pkg;

	// ==========================================
	// Timing
	localparam int CLK_HZ           = 50_000_000;
	localparam int CLK_PERIOD_NS    = 20;
	localparam int DELAY_TIME_MS    = 72;
	localparam int RC_OSC_HZ        = 1_000_000;
	localparam int DELAY_TICKS      = DELAY_TIME_MS * (RC_OSC_HZ / 1000);
	localparam int BROWN_MIN_US     = 100;
	localparam int BROWN_MIN_CYCLES = (BROWN_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_WAIT_CYCLES  = 1024;
	localparam int TMR_W            = 17;
	// Synchroniser reset levels: poweron detect and master clear high
	localparam logic [4:0] SYNC_INIT = 5'h03;

	// ==========================================
	// Program counter vectors
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INT_VECTOR   = 13'h0004;

	// ==========================================
	// Register map and fields
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int CFG_DELAY_BIT  = 0;
	localparam int CFG_BROWN_BIT  = 1;
	localparam int CFG_OSC_LSB    = 2;
	localparam int CFG_SKIP_BIT   = 4;
	localparam int STS_STATE_LSB  = 0;
	localparam int STS_CAUSE_LSB  = 3;
	localparam int STS_RESET_BIT  = 6;
	localparam int STS_WAKE_LSB   = 8;
	localparam logic CFG_DELAY_RST = 1'b1;
	localparam logic CFG_BROWN_RST = 1'b1;
	localparam logic CFG_SKIP_RST  = 1'b0;

	// ==========================================
	// Enumerations
	typedef enum logic [1:0] {OSC_RC, OSC_LOWPOWER, OSC_CRYSTAL, OSC_HIGHSPEED} rss_osc_type;
	typedef enum logic [2:0] {ST_HOLD, ST_POWERUP, ST_OSCSTART, ST_WAKESTART, ST_RUN, ST_SLEEP} rss_seq_type;
	typedef enum logic [2:0] {CAUSE_POWERON, CAUSE_BROWNOUT, CAUSE_MASTERCLEAR, CAUSE_WATCHDOG,
		CAUSE_WAKE} rss_cause_type;

	localparam rss_osc_type CFG_OSC_RST = OSC_CRYSTAL;

endpackage

//--- rtl/rss_tmr_if.sv
`timescale 1ns/1ps
interface rss_tmr_if #(parameter int TW = rss_pkg::TMR_W);
	logic          clear;
	logic          tick;
	logic [TW-1:0] limit;
	logic          done;
	modport ctl (output clear, output tick, output limit, input done);
	modport timer (input clear, input tick, input limit, output done);
endinterface

//--- rtl/rss_sync.sv
`timescale 1ns/1ps
module rss_sync #(
	parameter int           N    = 5,
	parameter logic [N-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] din,
	output logic      [N-1:0] dout
);
	typedef struct packed {
		logic [N-1:0] first;
		logic [N-1:0] second;
	} rss_sync_type;

	rss_sync_type st;
	rss_sync_type next_st;

	always_comb begin
		next_st.first  = din;
		next_st.second = st.first;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= {INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.second;
endmodule // rss_sync

//--- rtl/rss_timer.sv
`timescale 1ns/1ps
module rss_timer #(
	parameter int TW = rss_pkg::TMR_W
) (
	input wire logic clk,
	input wire logic reset,
	rss_tmr_if.timer tmr
);
	typedef struct packed {
		logic [TW-1:0] count;
	} rss_timer_type;

	rss_timer_type st;
	rss_timer_type next_st;

	// ==========================================
	// Saturating tick counter
	always_comb begin
		next_st = st;
		if (tmr.clear) begin
			next_st.count = '0;
		end else if (tmr.tick && st.count != tmr.limit) begin
			next_st.count = st.count + TW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tmr.done = (st.count == tmr.limit);

	chk_timer_clear_zero: assert property (@(posedge clk) disable iff (reset)
		tmr.clear |=> st.count == '0) else $error("timer not cleared");
endmodule // rss_timer

//--- rtl/rss_sequencer.sv
`timescale 1ns/1ps
module rss_sequencer #(
	parameter int DELAY_TICKS      = rss_pkg::DELAY_TICKS,
	parameter int BROWN_MIN_CYCLES = rss_pkg::BROWN_MIN_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        powerOnDetect,
	input  wire logic        brownoutDetect,
	input  wire logic        masterClearPinN,
	input  wire logic        rcOscPin,
	input  wire logic        oscillatorInputPin,
	input  wire logic        watchdogTimeout,
	input  wire logic        sleepEnter,
	input  wire logic        wakeEvent,
	input  wire logic        wakeByInterrupt,
	input  wire logic        globalInterruptEnable,
	input  wire logic [7:0]  wakeSources,
	output logic             chipReset,
	output logic             converterReset,
	output logic             dataRegsUnknown,
	output logic             controlRegsClear,
	output logic             directionRegsOnes,
	output logic             portLatchUnknown,
	output logic             pcLoad,
	output logic             pcAdvance,
	output logic      [12:0] pcVector,
	output logic             wakeFlagSet,
	output logic      [7:0]  wakeFlags,
	output logic      [2:0]  resetCause
);
	localparam int TW = rss_pkg::TMR_W;

	typedef struct packed {
		rss_pkg::rss_seq_type   state;
		rss_pkg::rss_cause_type cause;
		logic                   chipReset;
		logic                   converterReset;
		logic                   dataUnknown;
		logic                   ctrlClear;
		logic                   dirOnes;
		logic                   latchUnknown;
		logic                   pcLoad;
		logic                   pcAdvance;
		logic [12:0]            pcVector;
		logic                   wakeSet;
		logic [7:0]             wakeFlags;
		logic                   wakeIntVec;
		logic                   rcPrev;
		logic                   oscPrev;
		logic                   waitReq;
		logic [31:0]            readData;
		logic                   delayFuse;
		logic                   brownFuse;
		logic                   waitSkip;
		rss_pkg::rss_osc_type   oscMode;
	} rss_seq_state_type;

	rss_seq_state_type st;
	rss_seq_state_type next_st;

	// ==========================================
	// Input synchronisers
	logic [4:0] syncOut;
	logic       porS;
	logic       brownS;
	logic       clearSN;
	logic       rcS;
	logic       oscS;

	rss_sync #(.N(5), .INIT(rss_pkg::SYNC_INIT)) u_sync (
		.clk   (clk),
		.reset (reset),
		.din   ({oscillatorInputPin, rcOscPin, brownoutDetect, masterClearPinN, powerOnDetect}),
		.dout  (syncOut)
	);
	assign porS    = syncOut[0];
	assign clearSN = syncOut[1];
	assign brownS  = syncOut[2];
	assign rcS     = syncOut[3];
	assign oscS    = syncOut[4];

	// ==========================================
	// Timers
	rss_tmr_if #(.TW(TW)) delayIf ();
	rss_tmr_if #(.TW(TW)) oscWaitIf ();
	rss_tmr_if #(.TW(TW)) brownIf ();

	rss_timer #(.TW(TW)) u_delay (.clk(clk), .reset(reset), .tmr(delayIf.timer));
	rss_timer #(.TW(TW)) u_oscwait (.clk(clk), .reset(reset), .tmr(oscWaitIf.timer));
	rss_timer #(.TW(TW)) u_brown (.clk(clk), .reset(reset), .tmr(brownIf.timer));

	logic brownLow;
	logic brownEvent;
	logic xtalMode;
	logic supplyOk;
	logic release_;
	logic busReq;

	assign brownLow   = st.brownFuse && brownS;
	assign brownEvent = brownLow && brownIf.done;
	assign xtalMode   = st.oscMode != rss_pkg::OSC_RC;
	assign supplyOk   = !porS && !brownLow && clearSN;

	assign delayIf.clear   = st.state != rss_pkg::ST_POWERUP;
	assign delayIf.tick    = rcS && !st.rcPrev;
	assign delayIf.limit   = TW'(DELAY_TICKS);
	assign oscWaitIf.clear = !(st.state inside {rss_pkg::ST_OSCSTART, rss_pkg::ST_WAKESTART});
	assign oscWaitIf.tick  = oscS && !st.oscPrev;
	assign oscWaitIf.limit = TW'(rss_pkg::OSC_WAIT_CYCLES);
	assign brownIf.clear   = !brownLow;
	assign brownIf.tick    = 1'b1;
	assign brownIf.limit   = TW'(BROWN_MIN_CYCLES);

	assign busReq = read || write;

	// ==========================================
	// Sequencer and register next state
	always_comb begin
		next_st           = st;
		release_          = 1'b0;
		next_st.pcLoad    = 1'b0;
		next_st.pcAdvance = 1'b0;
		next_st.wakeSet   = 1'b0;
		next_st.rcPrev    = rcS;
		next_st.oscPrev   = oscS;

		case (st.state)
			rss_pkg::ST_RUN: begin
				if (watchdogTimeout) begin
					next_st.state = rss_pkg::ST_HOLD;
					next_st.cause = rss_pkg::CAUSE_WATCHDOG;
				end else if (sleepEnter) begin
					next_st.state = rss_pkg::ST_SLEEP;
				end
			end
			rss_pkg::ST_SLEEP: begin
				if (wakeEvent) begin
					next_st.cause      = rss_pkg::CAUSE_WAKE;
					next_st.wakeSet    = 1'b1;
					next_st.wakeFlags  = wakeSources;
					next_st.wakeIntVec = wakeByInterrupt && globalInterruptEnable;
					if (xtalMode && !st.waitSkip) begin
						next_st.state = rss_pkg::ST_WAKESTART;
					end else begin
						release_ = 1'b1;
					end
				end
			end
			rss_pkg::ST_HOLD: begin
				if (supplyOk) begin
					if (st.cause inside {rss_pkg::CAUSE_POWERON, rss_pkg::CAUSE_BROWNOUT} &&
						(st.delayFuse || st.brownFuse)) begin
						next_st.state = rss_pkg::ST_POWERUP;
					end else if (st.cause == rss_pkg::CAUSE_POWERON && xtalMode) begin
						next_st.state = rss_pkg::ST_OSCSTART;
					end else begin
						release_ = 1'b1;
					end
				end
			end
			rss_pkg::ST_POWERUP: begin
				if (delayIf.done) begin
					if (st.cause == rss_pkg::CAUSE_POWERON && xtalMode) begin
						next_st.state = rss_pkg::ST_OSCSTART;
					end else begin
						release_ = 1'b1;
					end
				end
			end
			rss_pkg::ST_OSCSTART, rss_pkg::ST_WAKESTART: begin
				if (oscWaitIf.done) begin
					release_ = 1'b1;
				end
			end
			default: begin
				next_st.state = rss_pkg::ST_HOLD;
			end
		endcase

		if (release_) begin
			next_st.state = rss_pkg::ST_RUN;
			if (next_st.cause != rss_pkg::CAUSE_WAKE) begin
				next_st.pcLoad   = 1'b1;
				next_st.pcVector = rss_pkg::RESET_VECTOR;
			end else if (next_st.wakeIntVec) begin
				next_st.pcLoad   = 1'b1;
				next_st.pcVector = rss_pkg::INT_VECTOR;
			end else begin
				next_st.pcAdvance = 1'b1;
			end
		end

		if (porS) begin
			next_st.state = rss_pkg::ST_HOLD;
			next_st.cause = rss_pkg::CAUSE_POWERON;
		end else if (brownEvent) begin
			next_st.state = rss_pkg::ST_HOLD;
			next_st.cause = rss_pkg::CAUSE_BROWNOUT;
		end else if (!clearSN) begin
			next_st.state = rss_pkg::ST_HOLD;
			next_st.cause = rss_pkg::CAUSE_MASTERCLEAR;
		end

		next_st.chipReset      = !(next_st.state inside {rss_pkg::ST_RUN, rss_pkg::ST_SLEEP});
		next_st.converterReset = next_st.chipReset && next_st.cause != rss_pkg::CAUSE_WAKE;
		next_st.dataUnknown    = next_st.converterReset &&
			next_st.cause inside {rss_pkg::CAUSE_POWERON, rss_pkg::CAUSE_BROWNOUT};
		next_st.ctrlClear      = next_st.converterReset;
		next_st.dirOnes        = next_st.converterReset;
		next_st.latchUnknown   = next_st.dataUnknown;

		// Avalon slave: one wait cycle, answer in the second
		next_st.waitReq  = !(busReq && st.waitReq);
		next_st.readData = '0;
		if (read && address == rss_pkg::ADDR_CONFIG) begin
			next_st.readData[rss_pkg::CFG_DELAY_BIT]       = st.delayFuse;
			next_st.readData[rss_pkg::CFG_BROWN_BIT]       = st.brownFuse;
			next_st.readData[rss_pkg::CFG_OSC_LSB +: 2]    = st.oscMode;
			next_st.readData[rss_pkg::CFG_SKIP_BIT]        = st.waitSkip;
		end else if (read && address == rss_pkg::ADDR_STATUS) begin
			next_st.readData[rss_pkg::STS_STATE_LSB +: 3]  = st.state;
			next_st.readData[rss_pkg::STS_CAUSE_LSB +: 3]  = st.cause;
			next_st.readData[rss_pkg::STS_RESET_BIT]       = st.chipReset;
			next_st.readData[rss_pkg::STS_WAKE_LSB +: 8]   = st.wakeFlags;
		end
		if (write && !st.waitReq && address == rss_pkg::ADDR_CONFIG) begin
			next_st.delayFuse = writedata[rss_pkg::CFG_DELAY_BIT];
			next_st.brownFuse = writedata[rss_pkg::CFG_BROWN_BIT];
			next_st.oscMode   = rss_pkg::rss_osc_type'(writedata[rss_pkg::CFG_OSC_LSB +: 2]);
			next_st.waitSkip  = writedata[rss_pkg::CFG_SKIP_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st                <= '0;
			st.state          <= rss_pkg::ST_HOLD;
			st.cause          <= rss_pkg::CAUSE_POWERON;
			st.chipReset      <= 1'b1;
			st.converterReset <= 1'b1;
			st.dataUnknown    <= 1'b1;
			st.ctrlClear      <= 1'b1;
			st.dirOnes        <= 1'b1;
			st.latchUnknown   <= 1'b1;
			st.waitReq        <= 1'b1;
			st.delayFuse      <= rss_pkg::CFG_DELAY_RST;
			st.brownFuse      <= rss_pkg::CFG_BROWN_RST;
			st.waitSkip       <= rss_pkg::CFG_SKIP_RST;
			st.oscMode        <= rss_pkg::CFG_OSC_RST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign readdata          = st.readData;
	assign waitrequest       = st.waitReq;
	assign chipReset         = st.chipReset;
	assign converterReset    = st.converterReset;
	assign dataRegsUnknown   = st.dataUnknown;
	assign controlRegsClear  = st.ctrlClear;
	assign directionRegsOnes = st.dirOnes;
	assign portLatchUnknown  = st.latchUnknown;
	assign pcLoad            = st.pcLoad;
	assign pcAdvance         = st.pcAdvance;
	assign pcVector          = st.pcVector;
	assign wakeFlagSet       = st.wakeSet;
	assign wakeFlags         = st.wakeFlags;
	assign resetCause        = st.cause;

	// ==========================================
	// Checks
	chk_poweron_resets: assert property (@(posedge clk) disable iff (reset)
		porS |=> chipReset && resetCause == rss_pkg::CAUSE_POWERON) else $error("poweron not held");
	chk_powerup_holds: assert property (@(posedge clk) disable iff (reset)
		st.state == rss_pkg::ST_POWERUP |-> chipReset) else $error("released during power-up delay");
	chk_fuse_forces_timer: assert property (@(posedge clk) disable iff (reset)
		$rose(st.state == rss_pkg::ST_POWERUP) |-> $past(st.delayFuse || st.brownFuse))
		else $error("power-up delay ran without fuse");
	chk_osc_only_poweron: assert property (@(posedge clk) disable iff (reset)
		st.state == rss_pkg::ST_OSCSTART |-> st.cause == rss_pkg::CAUSE_POWERON && xtalMode)
		else $error("oscillator wait in wrong case");
	chk_brownout_restart: assert property (@(posedge clk) disable iff (reset)
		(st.state == rss_pkg::ST_POWERUP && brownEvent && !porS) |=>
		st.state == rss_pkg::ST_HOLD && resetCause == rss_pkg::CAUSE_BROWNOUT)
		else $error("brownout did not restart");
	chk_converter_reset: assert property (@(posedge clk) disable iff (reset)
		(chipReset && resetCause != rss_pkg::CAUSE_WAKE) |-> converterReset) else $error("converter not reset");
	chk_reset_vector: assert property (@(posedge clk) disable iff (reset)
		(pcLoad && resetCause != rss_pkg::CAUSE_WAKE) |-> pcVector == rss_pkg::RESET_VECTOR)
		else $error("wrong reset vector");
	chk_direction_wake: assert property (@(posedge clk) disable iff (reset)
		directionRegsOnes |-> resetCause != rss_pkg::CAUSE_WAKE) else $error("directions set on wake");
	chk_wake_flags: assert property (@(posedge clk) disable iff (reset)
		(st.state == rss_pkg::ST_SLEEP && wakeEvent && !porS && !brownEvent && clearSN) |=>
		wakeFlagSet && wakeFlags == $past(wakeSources)) else $error("wake flags not set");
endmodule // rss_sequencer

//--- dv/rss_far_model.sv
`timescale 1ns/1ps
// ==========================================
// Far side: supply detectors, master clear pin, RC and crystal oscillators
module rss_far_model #(
	parameter int RC_HALF  = 3,
	parameter int OSC_HALF = 2
) (
	input  wire logic clk,
	input  wire logic supplyLow,
	input  wire logic supplyBrown,
	input  wire logic clearLow,
	output logic      powerOnDetect,
	output logic      brownoutDetect,
	output logic      masterClearPinN,
	output logic      rcOscPin,
	output logic      oscillatorInputPin
);
	int rcCnt  = 0;
	int oscCnt = 0;
	initial rcOscPin = 1'b0;
	initial oscillatorInputPin = 1'b0;
	// Detector levels follow the supply as commanded
	assign powerOnDetect   = supplyLow;
	assign brownoutDetect  = supplyBrown;
	assign masterClearPinN = ~clearLow;
	// Both oscillators are divided from clk: RC toggles every RC_HALF cycles, crystal every OSC_HALF cycles
	always @(posedge clk) begin
		rcCnt  <= (rcCnt == RC_HALF - 1) ? 0 : rcCnt + 1;
		oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
		if (rcCnt == RC_HALF - 1) rcOscPin <= ~rcOscPin;
		if (oscCnt == OSC_HALF - 1) oscillatorInputPin <= ~oscillatorInputPin;
	end
endmodule // rss_far_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int PW = 8;
	localparam int RH = 3;
	localparam int OH = 2;
	logic        clk, reset, read, write, sLow, sBrown, cLow;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic        waitrequest, poD, boD, mcN, rcP, oscP, wdt, slp, wake, wInt, global_interrupt_enable;
	logic [7:0]  wakeSources, wakeFlags, ws;
	logic        chipReset, converterReset, dataRegsUnknown, controlRegsClear, directionRegsOnes;
	logic        portLatchUnknown, pcLoad, pcAdvance, wakeFlagSet, adv;
	logic [12:0] pcVector, vec;
	logic [2:0]  resetCause;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          seed = 49622;
	int          cyc;

	rss_far_model #(.RC_HALF(RH), .OSC_HALF(OH)) farSide (.clk(clk), .supplyLow(sLow), .supplyBrown(sBrown),
		.clearLow(cLow), .powerOnDetect(poD), .brownoutDetect(boD), .masterClearPinN(mcN), .rcOscPin(rcP),
		.oscillatorInputPin(oscP));

	rss_sequencer #(.DELAY_TICKS(PW), .BROWN_MIN_CYCLES(4)) DUT (.clk(clk), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.powerOnDetect(poD), .brownoutDetect(boD), .masterClearPinN(mcN), .rcOscPin(rcP),
		.oscillatorInputPin(oscP), .watchdogTimeout(wdt), .sleepEnter(slp), .wakeEvent(wake),
		.wakeByInterrupt(wInt), .globalInterruptEnable(global_interrupt_enable), .wakeSources(wakeSources),
		.chipReset(chipReset), .converterReset(converterReset), .dataRegsUnknown(dataRegsUnknown),
		.controlRegsClear(controlRegsClear), .directionRegsOnes(directionRegsOnes),
		.portLatchUnknown(portLatchUnknown), .pcLoad(pcLoad), .pcAdvance(pcAdvance), .pcVector(pcVector),
		.wakeFlagSet(wakeFlagSet), .wakeFlags(wakeFlags), .resetCause(resetCause));

	// ==========================================
	// Shared tasks
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic int tmin(input int edges, input int half);
		return (edges - 1) * 2 * half;
	endfunction

	function automatic int tmax(input int edges, input int half);
		return (edges + 1) * 2 * half + 12;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
		int n;
		n = 0;
		address <= a;
		writedata <= wd;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0);
		r = readdata;
		chk(n, 32'h2);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic cfg(input logic skip, input logic [1:0] osc, input logic brownout_enable_fuse, input logic power_up_delay_timer);
		bus(1'b1, rss_pkg::ADDR_CONFIG, {27'h0, skip, osc, brownout_enable_fuse, power_up_delay_timer}, rd);
	endtask

	// Count cycles until the release pulse
	task automatic rel(input int lo, input int hi);
		cyc = 0;
		do begin
			@(posedge clk);
			cyc++;
		end while (pcLoad !== 1'b1 && pcAdvance !== 1'b1 && cyc < 9000);
		vec = pcVector;
		adv = pcAdvance;
		chk(32'(cyc >= lo && cyc <= hi), 32'h1);
		chk(chipReset, 32'h0);
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic po(input int lo, input int hi);
		sLow <= 1'b1;
		hold(4);
		chk(chipReset, 32'h1);
		chk({dataRegsUnknown, portLatchUnknown, directionRegsOnes, converterReset}, 32'hf);
		sLow <= 1'b0;
		rel(lo, hi);
		chk(vec, 32'h0);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		reset = 1'b1;
		{read, write, sLow, sBrown, cLow, wdt, slp, wake, wInt, global_interrupt_enable} = '0;
		address = 4'h0;
		writedata = 32'h0;
		wakeSources = 8'h0;
		sLow = 1'b1;
		hold(20);
		reset <= 1'b0;
		hold(1);
		bus(1'b0, rss_pkg::ADDR_STATUS, 32'h0, rd);
		chk(rd, 32'h40);
		bus(1'b0, rss_pkg::ADDR_CONFIG, 32'h0, rd);
		chk(rd, 32'h0b);
		bus(1'b0, 4'h8, 32'h0, rd);
		chk(rd, 32'h0);
		sLow <= 1'b0;
		rel(tmin(PW, RH) + tmin(1024, OH), tmax(PW, RH) + tmax(1024, OH));
		chk({vec, resetCause}, 32'h0);
		cfg(1'b0, 2'h0, 1'b0, 1'b0);
		po(1, 12);
		cfg(1'b0, 2'h0, 1'b1, 1'b0);
		po(tmin(PW, RH), tmax(PW, RH));
		cfg(1'b0, 2'h3, 1'b0, 1'b0);
		po(tmin(1024, OH), tmax(1024, OH));
		sBrown <= 1'b1;
		hold(8);
		chk(chipReset, 32'h0);
		sBrown <= 1'b0;
		cfg(1'b0, 2'h1, 1'b1, 1'b1);
		sBrown <= 1'b1;
		hold(2);
		sBrown <= 1'b0;
		hold(8);
		chk(chipReset, 32'h0);
		sBrown <= 1'b1;
		hold(10);
		chk({chipReset, resetCause, dataRegsUnknown, controlRegsClear}, 32'h27);
		sBrown <= 1'b0;
		hold(4 + (($random(seed) & 32'h7) + 4));
		sBrown <= 1'b1;
		hold(10);
		sBrown <= 1'b0;
		rel(tmin(PW, RH), tmax(PW, RH));
		chk({vec, resetCause}, 32'h1);
		cLow <= 1'b1;
		hold(6);
		chk({chipReset, resetCause, dataRegsUnknown, controlRegsClear, directionRegsOnes}, 32'h53);
		cLow <= 1'b0;
		rel(1, 12);
		wdt <= 1'b1;
		hold(1);
		wdt <= 1'b0;
		rel(1, 12);
		chk({vec, resetCause}, 32'h3);
		for (int k = 0; k < 2; k++) begin
			ws = 8'($random(seed));
			cfg(k[0], 2'h2, 1'b1, 1'b1);
			slp <= 1'b1;
			hold(1);
			slp <= 1'b0;
			wake <= 1'b1;
			wInt <= ~k[0];
			global_interrupt_enable <= 1'b1;
			wakeSources <= ws;
			hold(1);
			wake <= 1'b0;
			hold(1);
			chk({wakeFlagSet, wakeFlags}, {23'h0, 1'b1, ws});
			chk({resetCause, converterReset, directionRegsOnes, portLatchUnknown}, 32'h20);
			if (k == 0) begin
				rel(tmin(1024, OH), tmax(1024, OH));
				chk({adv, vec}, 32'h4);
			end else begin
				chk({pcAdvance, pcLoad, chipReset}, 32'h4);
				chk(controlRegsClear, 32'h0);
				chk({pcAdvance, pcLoad}, 32'h2);
			end
		end
		end_of_test();
	end

	initial begin
		#1_000_000;
		error_cnt++;
		end_of_test();
	end
endmodule // testbench
